/* vcom_bridge_pkg.sv */
// shared constants and types of the serial bridge
`default_nettype none
package vcom_bridge_pkg;

  // ==========================================================
  // clock and link rates
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_RESET = 115_200;
  localparam int unsigned BAUD_MIN = 9_600;
  localparam int unsigned BAUD_MAX = 921_600;
  // clocks per bit; the fastest rate rounds down, the slowest too
  localparam int unsigned DIV_RESET_I = CLK_HZ / BAUD_RESET;
  localparam int unsigned DIV_MIN_I = CLK_HZ / BAUD_MAX;
  localparam int unsigned DIV_MAX_I = CLK_HZ / BAUD_MIN;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(DIV_RESET_I);
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(DIV_MIN_I);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(DIV_MAX_I);

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_TXDATA = 8'h10;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned ST_RX_VALID = 0;
  localparam int unsigned ST_RX_FULL = 1;
  localparam int unsigned ST_TX_BUSY = 2;
  localparam int unsigned ST_TX_PEND = 3;
  localparam int unsigned ST_FRAME_ERR = 4;
  localparam int unsigned ST_RX_OVR = 5;
  localparam int unsigned ST_TX_DROP = 6;
  localparam int unsigned ST_PATH_EN = 7;
  localparam int unsigned ST_TGT_RTS = 8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {HS_DISABLED, HS_RTS, HS_CTS, HS_RTSCTS} hs_mode_t;
  localparam hs_mode_t MODE_RESET = HS_DISABLED;

  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} ser_state_t;

  // a pin that the bridge may leave undriven
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage
`default_nettype wire

/* vcom_uart_bridge.sv */
// serial bridge end of the target link, with apb registers and flow control
//
// What this block does
// - reset: 115200 8N1, flow control off
// - rate 9600..921600, shared by both directions
// - target tx into bridge, bridge out
// - nothing relayed while path enable low
// - ready output high when buffer has room
// - ready output low when buffer full
// - disabled: ready undriven, target rts ignored
// - rts mode: ready driven, target rts ignored
// - cts mode: ready undriven, send gated
// - rtscts mode: ready driven and send gated
// - running character always finishes
// - no gating: send regardless of rts
`timescale 1ns/1ps
`default_nettype none

module vcom_uart_bridge
  import vcom_bridge_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // target link pins
  input wire logic tgt_txd,
  output logic tgt_rxd,
  input wire logic tgt_rts,
  output pin_drive_t tgt_cts,
  input wire logic path_en
);

  // ==========================================================
  // elaboration check
  if (DATA_W != 8) begin : g_chk
    $error("vcom_uart_bridge supports 8 data bits only");
  end

  // ==========================================================
  // state
  typedef struct packed {
    hs_mode_t mode;
    logic [DIV_W-1:0] div;
    logic [2:0] s_line;
    logic f_line;
    logic [2:0] s_en;
    logic f_en;
    logic [2:0] s_rts;
    logic f_rts;
    ser_state_t rx_st;
    logic [DIV_W-1:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [1:0][7:0] buf_q;
    logic [1:0] buf_n;
    ser_state_t tx_st;
    logic [DIV_W-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_line;
    logic [7:0] hold;
    logic hold_v;
    logic ferr;
    logic ovr;
    logic drop;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  localparam state_t ST_RESET = '{
    mode: MODE_RESET,
    div: DIV_RESET,
    s_line: 3'b111,
    f_line: 1'b1,
    s_en: 3'b000,
    f_en: 1'b0,
    s_rts: 3'b000,
    f_rts: 1'b0,
    rx_st: SER_IDLE,
    rx_cnt: '0,
    rx_bit: 3'd0,
    rx_sh: 8'h00,
    buf_q: '0,
    buf_n: 2'd0,
    tx_st: SER_IDLE,
    tx_cnt: '0,
    tx_bit: 3'd0,
    tx_sh: 8'h00,
    tx_line: 1'b1,
    hold: 8'h00,
    hold_v: 1'b0,
    ferr: 1'b0,
    ovr: 1'b0,
    drop: 1'b0,
    rdata: 32'h0000_0000
  };

  // ==========================================================
  // bus decode
  logic setup;
  logic access;
  logic mapped;
  logic wr_en;
  logic rd_en;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_DIV) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_RXDATA) || (paddr == OFS_TXDATA);
  assign wr_en = access && pwrite && mapped;
  assign rd_en = access && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ==========================================================
  // buffer handshakes: fill from the receiver, drain by bus reads
  logic fill_valid;
  logic fill_ready;
  logic drain_valid;
  logic drain_ready;
  logic gate_tx;
  logic drive_ready;
  logic tx_take;

  always_comb begin
    state_t n;
    logic [31:0] status;
    logic [1:0] cnt_after;
    logic [DIV_W-1:0] wdiv;
    n = st_r;
    fill_valid = 1'b0;
    drain_valid = st_r.buf_n != 2'd0;
    drain_ready = rd_en && (paddr == OFS_RXDATA);
    fill_ready = st_r.buf_n != 2'd2;
    gate_tx = (st_r.mode == HS_CTS) || (st_r.mode == HS_RTSCTS);
    drive_ready = (st_r.mode == HS_RTS) || (st_r.mode == HS_RTSCTS);
    tx_take = (st_r.tx_st == SER_IDLE) && st_r.hold_v && st_r.f_en && (!gate_tx || st_r.f_rts);
    wdiv = '0;
    status = 32'h0000_0000;
    status[ST_RX_VALID] = drain_valid;
    status[ST_RX_FULL] = !fill_ready;
    status[ST_TX_BUSY] = st_r.tx_st != SER_IDLE;
    status[ST_TX_PEND] = st_r.hold_v;
    status[ST_FRAME_ERR] = st_r.ferr;
    status[ST_RX_OVR] = st_r.ovr;
    status[ST_TX_DROP] = st_r.drop;
    status[ST_PATH_EN] = st_r.f_en;
    status[ST_TGT_RTS] = st_r.f_rts;

    // pin inputs: the filtered level moves once stages two and three agree
    n.s_line = {st_r.s_line[1:0], tgt_txd};
    n.s_en = {st_r.s_en[1:0], path_en};
    n.s_rts = {st_r.s_rts[1:0], tgt_rts};
    if (st_r.s_line[1] == st_r.s_line[2]) begin
      n.f_line = st_r.s_line[2];
    end
    if (st_r.s_en[1] == st_r.s_en[2]) begin
      n.f_en = st_r.s_en[2];
    end
    if (st_r.s_rts[1] == st_r.s_rts[2]) begin
      n.f_rts = st_r.s_rts[2];
    end

    // read data is captured in the setup cycle so it comes from flops
    if (setup && !pwrite) begin
      case (paddr)
        OFS_CTRL: n.rdata = {30'h0000_0000, st_r.mode};
        OFS_DIV: n.rdata = {16'h0000, st_r.div};
        OFS_STATUS: n.rdata = status;
        OFS_RXDATA: n.rdata = {24'h00_0000, st_r.buf_q[0]};
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // register writes; sticky flags are write-one-to-clear
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: n.mode = hs_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
        OFS_DIV: begin
          wdiv = pwdata[DIV_W-1:0];
          if (wdiv < DIV_MIN) begin
            n.div = DIV_MIN;
          end else if (wdiv > DIV_MAX) begin
            n.div = DIV_MAX;
          end else begin
            n.div = wdiv;
          end
        end
        OFS_STATUS: begin
          if (pwdata[ST_FRAME_ERR]) begin
            n.ferr = 1'b0;
          end
          if (pwdata[ST_RX_OVR]) begin
            n.ovr = 1'b0;
          end
          if (pwdata[ST_TX_DROP]) begin
            n.drop = 1'b0;
          end
        end
        OFS_TXDATA: begin
          // a full holding register refuses the byte unless it is taken now
          if (st_r.hold_v && !tx_take) begin
            n.drop = 1'b1;
          end else begin
            n.hold = pwdata[7:0];
            n.hold_v = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // ==========================================================
    // receiver, target to bridge
    // target data in
    n.rx_cnt = (st_r.rx_cnt == '0) ? '0 : st_r.rx_cnt - 1'b1;
    case (st_r.rx_st)
      SER_IDLE: begin
        if (st_r.f_en && !st_r.f_line) begin
          n.rx_st = SER_START;
          n.rx_cnt = st_r.div >> 1;
        end
      end
      SER_START: begin
        if (st_r.rx_cnt == '0) begin
          if (!st_r.f_line) begin
            n.rx_st = SER_DATA;
            n.rx_bit = 3'd0;
            n.rx_cnt = st_r.div - 1'b1;
          end else begin
            n.rx_st = SER_IDLE;
          end
        end
      end
      SER_DATA: begin
        if (st_r.rx_cnt == '0) begin
          n.rx_sh = {st_r.f_line, st_r.rx_sh[7:1]};
          n.rx_cnt = st_r.div - 1'b1;
          n.rx_bit = st_r.rx_bit + 3'd1;
          if (st_r.rx_bit == 3'd7) begin
            n.rx_st = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (st_r.rx_cnt == '0) begin
          n.rx_st = SER_IDLE;
          if (st_r.f_line) begin
            fill_valid = 1'b1;
          end else begin
            n.ferr = 1'b1;
          end
        end
      end
      default: n.rx_st = SER_IDLE;
    endcase

    // ==========================================================
    // two-entry buffer
    cnt_after = st_r.buf_n;
    if (drain_valid && drain_ready) begin
      n.buf_q[0] = st_r.buf_q[1];
      cnt_after = st_r.buf_n - 2'd1;
    end
    if (fill_valid) begin
      if (fill_ready || (drain_valid && drain_ready)) begin
        n.buf_q[cnt_after[0]] = st_r.rx_sh;
        cnt_after = cnt_after + 2'd1;
      end else begin
        // the buffer is full and no read drains it this cycle; the new byte is lost
        n.ovr = 1'b1;
      end
    end
    n.buf_n = cnt_after;

    // ==========================================================
    // transmitter, bridge to target
    n.tx_cnt = (st_r.tx_cnt == '0) ? '0 : st_r.tx_cnt - 1'b1;
    case (st_r.tx_st)
      SER_IDLE: begin
        n.tx_line = 1'b1;
        // no new character while path disabled
        if (tx_take) begin
          n.tx_st = SER_START;
          n.tx_sh = st_r.hold;
          n.hold_v = (wr_en && (paddr == OFS_TXDATA));
          n.tx_line = 1'b0;
          n.tx_cnt = st_r.div - 1'b1;
        end
      end
      SER_START: begin
        if (st_r.tx_cnt == '0) begin
          n.tx_st = SER_DATA;
          n.tx_bit = 3'd0;
          n.tx_line = st_r.tx_sh[0];
          n.tx_cnt = st_r.div - 1'b1;
        end
      end
      SER_DATA: begin
        // rts is not looked at mid-character
        if (st_r.tx_cnt == '0) begin
          n.tx_cnt = st_r.div - 1'b1;
          n.tx_bit = st_r.tx_bit + 3'd1;
          if (st_r.tx_bit == 3'd7) begin
            n.tx_st = SER_STOP;
            n.tx_line = 1'b1;
          end else begin
            n.tx_sh = {1'b0, st_r.tx_sh[7:1]};
            n.tx_line = st_r.tx_sh[1];
          end
        end
      end
      SER_STOP: begin
        if (st_r.tx_cnt == '0) begin
          n.tx_st = SER_IDLE;
        end
      end
      default: n.tx_st = SER_IDLE;
    endcase

    st_nxt = n;
  end

  // ==========================================================
  // registers
  // reset defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = st_r.rdata;
  assign tgt_rxd = st_r.tx_line;
  assign tgt_cts.out = fill_ready;
  assign tgt_cts.oe = drive_ready;

endmodule // vcom_uart_bridge
`default_nettype wire

/* vcom_uart_bridge_properties.sv */
// port assertions of the serial bridge
`timescale 1ns/1ps
`default_nettype none
module vcom_uart_bridge_properties
  import vcom_bridge_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link
  input wire logic tgt_txd,
  input wire logic tgt_rxd,
  input wire logic tgt_rts,
  input wire pin_drive_t tgt_cts,
  input wire logic path_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // mode shadow
  logic acc, bad, wr_ctl;
  logic [1:0] mode_r;
  assign acc = psel && penable;
  assign bad = paddr > OFS_TXDATA || paddr[1:0] != 2'b00;
  assign wr_ctl = acc && pwrite && ce && paddr == OFS_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 2'b00;
    end else if (wr_ctl) begin
      mode_r <= pwdata[1:0];
    end
  end
  sequence s_start;
    $fell(tgt_rxd);
  endsequence
  sequence s_low8;
    (!tgt_rxd)[*8];
  endsequence
  chk_cts_drive: assert property (tgt_cts.oe == mode_r[0])
    else $error("ready drive wrong for mode");
  chk_oe_steady: assert property (!wr_ctl |=> $stable(tgt_cts.oe))
    else $error("ready drive moved without write");
  chk_start_bit: assert property (s_start |-> s_low8)
    else $error("start bit too short");
  chk_bit_hold: assert property ($changed(tgt_rxd) |=> $stable(tgt_rxd)[*8])
    else $error("bit shorter than divisor");
  chk_room_pop: assert property ($rose(tgt_cts.out) |->
    $past(acc && !pwrite && paddr == OFS_RXDATA))
    else $error("ready rose without a pop");
  chk_unmapped_err: assert property (acc && bad |->
    pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  chk_err_only: assert property (pslverr |-> acc && bad)
    else $error("stray slave error");
  chk_ready_high: assert property (acc |-> pready)
    else $error("access not answered");
endmodule // vcom_uart_bridge_properties
`default_nettype wire

/* vcom_target_model.sv */
// behavioural target uart on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module vcom_target_model
  import vcom_bridge_pkg::*;
(
  // clock
  input wire logic pclk,
  // link
  input wire logic rxd,
  input wire pin_drive_t cts,
  output logic txd
);
  int div = DIV_RESET_I;
  logic [7:0] rb;
  logic [7:0] got[$];
  initial txd = 1'b1;
  // ==========
  // transmit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // hold off while bridge not ready
    while (cts.oe && !cts.out) @(posedge pclk);
    // start low, lsb first, stop high
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk) txd <= f[i];
      repeat (div - 1) @(posedge pclk);
    end
  endtask
  always begin
    @(negedge rxd);
    repeat (div / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge pclk);
      rb[i] = rxd;
    end
    repeat (div) @(posedge pclk);
    got.push_back(rb);
  end
endmodule // vcom_target_model
`default_nettype wire

/* vcom_uart_bridge_tb.sv */
// self-checking testbench of the serial bridge
`timescale 1ns/1ps
`default_nettype none
module vcom_uart_bridge_tb
  import vcom_bridge_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, txd, rxd;
  logic rts = 1'b0;
  logic pen = 1'b0;
  logic ce = 1'b1;
  pin_drive_t cts;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  vcom_uart_bridge DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tgt_txd(txd), .tgt_rxd(rxd),
    .tgt_rts(rts), .tgt_cts(cts), .path_en(pen));
  vcom_target_model tgt (.pclk(pclk), .rxd(rxd), .cts(cts), .txd(txd));
  initial forever #5 pclk = ~pclk;
  // ==========
  // tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends at the first edge that sees pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // a whole run needs about 26000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  // ==========
  // tests
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0000);
    apb(1'b0, OFS_DIV, 32'h0000_0000);
    chk("div", rd, 32'(DIV_RESET));
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    ce <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ce freeze", rd, 32'h0000_0000);
    apb(1'b1, OFS_DIV, 32'h0000_0000);
    apb(1'b0, OFS_DIV, 32'h0000_0000);
    chk("div min", rd, 32'(DIV_MIN));
    apb(1'b1, OFS_DIV, 32'h0000_FFFF);
    apb(1'b0, OFS_DIV, 32'h0000_0000);
    chk("div max", rd, 32'(DIV_MAX));
    apb(1'b1, OFS_DIV, 32'(DIV_MIN));
    tgt.div = DIV_MIN_I;
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("slverr", 32'(se), 32'h0000_0001);
    $display("test registers done");
    pen <= 1'b1;
    repeat (8) @(posedge pclk);
    tgt.send(8'hA5);
    repeat (300) @(posedge pclk);
    apb(1'b0, OFS_RXDATA, 32'h0000_0000);
    chk("rx byte", rd, 32'h0000_00A5);
    pen <= 1'b0;
    repeat (8) @(posedge pclk);
    tgt.send(8'h3C);
    apb(1'b1, OFS_TXDATA, 32'h0000_0077);
    apb(1'b1, OFS_TXDATA, 32'h0000_0078);
    repeat (1300) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("rx off", rd & 32'h0000_0001, 32'h0000_0000);
    chk("tx off", 32'(tgt.got.size()), 32'h0000_0000);
    chk("tx drop", rd & 32'h0000_0048, 32'h0000_0048);
    apb(1'b1, OFS_STATUS, 32'h0000_0040);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("drop clear", rd & 32'h0000_0040, 32'h0000_0000);
    pen <= 1'b1;
    repeat (1300) @(posedge pclk);
    chk("tx on", {24'h0, tgt.got[0]}, 32'h0000_0077);
    tgt.got.delete();
    $display("test path done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_CTRL, 32'(m));
      chk("drive", 32'(cts.oe), 32'(m[0]));
      rts <= 1'b0;
      apb(1'b1, OFS_TXDATA, 32'h0000_0040 + 32'(m));
      repeat (1300) @(posedge pclk);
      chk("gate", 32'(tgt.got.size()), m[1] ? 0 : 1);
      rts <= 1'b1;
      repeat (400) @(posedge pclk);
      rts <= 1'b0;
      repeat (1300) @(posedge pclk);
      chk("sent", {24'h0, tgt.got[0]}, 32'h0000_0040 + 32'(m));
      tgt.got.delete();
      if (m[0]) begin
        tgt.send(8'h01);
        tgt.send(8'h02);
        repeat (300) @(posedge pclk);
        chk("full", 32'(cts.out), 32'h0000_0000);
        apb(1'b0, OFS_RXDATA, 32'h0000_0000);
        chk("room", 32'(cts.out), 32'h0000_0001);
        chk("rx first", rd, 32'h0000_0001);
        apb(1'b0, OFS_RXDATA, 32'h0000_0000);
        chk("rx second", rd, 32'h0000_0002);
      end else if (m == 0) begin
        repeat (3) tgt.send(8'h55);
        repeat (300) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("overrun", rd & 32'h0000_0023, 32'h0000_0023);
        apb(1'b0, OFS_RXDATA, 32'h0000_0000);
        apb(1'b0, OFS_RXDATA, 32'h0000_0000);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("drained", rd & 32'h0000_0001, 32'h0000_0000);
      end
    end
    $display("test modes done");
    end_of_test();
  end
endmodule // vcom_uart_bridge_tb
bind vcom_uart_bridge vcom_uart_bridge_properties #(.DATA_W(DATA_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tgt_txd(tgt_txd), .tgt_rxd(tgt_rxd),
  .tgt_rts(tgt_rts), .tgt_cts(tgt_cts), .path_en(path_en));
`default_nettype wire
